//--- rtl/chb_pkg.sv
package chb_pkg;

  // ==========================================================
  // Modes, operations and carriers
  typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_IDE} chb_mode_t;
  typedef enum logic [1:0] {OP_TF, OP_CTRL, OP_DATA, OP_DMA} chb_op_t;

  typedef struct packed {
    chb_op_t op;
    logic wr;
    logic [2:0] reg_addr;
    logic [15:0] wdata;
    logic [7:0] words;
  } chb_cmd_t;

  typedef struct packed {
    logic [15:0] data;
    logic err;
  } chb_rsp_t;

  typedef struct packed {
    logic [10:0] addr;
    logic taskfile_select_n;
    logic ctrl_block_select_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic dma_grant_n;
    logic [15:0] data_out;
    logic [1:0] data_oe;
    logic role_out;
    logic role_oe;
  } chb_pins_t;

  // ==========================================================
  // Timing, in ns with the clock period in ps, and derived cycle counts
  localparam int CLK_PS = 5000;
  localparam int T_SETUP_NS = 70;
  localparam int T_STROBE_NS = 165;
  localparam int T_HOLD_NS = 30;
  localparam logic [7:0] SETUP_CYC =
    8'((T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] STROBE_CYC =
    8'((T_STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] HOLD_CYC =
    8'((T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // ==========================================================
  // Addresses and reset values
  localparam logic [2:0] DATA_REG_ADDR = 3'h0;
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_ALL = 2'h3;
  localparam chb_mode_t MODE_RESET = MODE_MEM;
  localparam chb_pins_t PINS_RESET = '{
    addr: 11'h000, taskfile_select_n: 1'b1, ctrl_block_select_n: 1'b1,
    io_read_strobe_n: 1'b1, io_write_strobe_n: 1'b1, dma_grant_n: 1'b1,
    data_out: 16'h0000, data_oe: 2'h0, role_out: 1'b0, role_oe: 1'b1};

endpackage : chb_pkg

//--- rtl/chb_sync.sv
`timescale 1ns/10ps

// ============================================================
// Two-flop synchroniser for pin inputs
module chb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // First stage feeds only the second
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule : chb_sync

//--- rtl/chb_host_ctrl.sv
`timescale 1ns/10ps

module chb_host_ctrl #(
  parameter bit DMA_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire chb_pkg::chb_mode_t bus_mode,
  input wire logic cfg_master,
  input wire logic a25_level,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire chb_pkg::chb_cmd_t cmd,
  input wire logic [15:0] dma_wr_data,
  output logic dma_wr_take,
  output logic rsp_valid,
  output chb_pkg::chb_rsp_t rsp,
  output chb_pkg::chb_pins_t pins,
  input wire logic [15:0] data_in,
  input wire logic input_ack_n,
  input wire logic dma_req_out
);

  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_DMA_WAIT,
    S_DMA_SETUP, S_DMA_STROBE, S_DMA_HOLD} chb_state_t;

  // ==========================================================
  // Pin input synchronisation
  logic [17:0] sync_q;
  logic [15:0] data_s;
  logic ack_n_s;
  logic req_s;

  chb_sync #(.W(18)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({dma_req_out, input_ack_n, data_in}),
    .q(sync_q)
  );
  assign data_s = sync_q[15:0];
  assign ack_n_s = sync_q[16];
  // Undriven request line is masked when DMA is not built in
  assign req_s = sync_q[17] & DMA_EN;

  // ==========================================================
  // Helpers
  function automatic chb_pkg::chb_pins_t idle_pins(
    input chb_pkg::chb_mode_t m, input logic master, input logic a25);
    chb_pkg::chb_pins_t p;
    p = chb_pkg::PINS_RESET;
    if (m == chb_pkg::MODE_IDE) begin
      p.role_out = 1'b0;
      p.role_oe = master;
    end else begin
      p.role_out = a25;
      p.role_oe = 1'b1;
    end
    return p;
  endfunction : idle_pins

  function automatic logic [7:0] dec(input logic [7:0] c);
    return c - 8'h01;
  endfunction : dec

  // ==========================================================
  // State
  chb_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] left_reg, left_next;
  chb_pkg::chb_cmd_t cmd_reg, cmd_next;
  chb_pkg::chb_mode_t mode_reg, mode_next;
  chb_pkg::chb_pins_t pins_reg, pins_next;
  chb_pkg::chb_rsp_t rsp_reg, rsp_next;
  logic ready_reg, ready_next;
  logic rsp_v_reg, rsp_v_next;
  logic take_reg, take_next;
  logic ack_reg, ack_next;
  logic role_reg, role_next;
  logic ack_now;

  assign ack_now = ack_reg | ~ack_n_s;

  // Role latched only in the reset cycle, so role_reg never moves later
  always_comb begin
    role_next = rst ? cfg_master : role_reg;
  end

  // Transfer sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    left_next = left_reg;
    cmd_next = cmd_reg;
    mode_next = mode_reg;
    pins_next = pins_reg;
    rsp_next = rsp_reg;
    ready_next = 1'b0;
    rsp_v_next = 1'b0;
    take_next = 1'b0;
    ack_next = ack_reg;
    case (st_reg)
      S_IDLE: begin
        ready_next = 1'b1;
        mode_next = bus_mode;
        pins_next = idle_pins(bus_mode, role_reg, a25_level);
        if (cmd_valid && ready_reg) begin
          ready_next = 1'b0;
          cmd_next = cmd;
          ack_next = 1'b0;
          left_next = cmd.words;
          rsp_next = '0;
          // No strobes in memory mode; DMA only in IDE mode
          if (bus_mode == chb_pkg::MODE_MEM ||
              (cmd.op == chb_pkg::OP_DMA &&
               (bus_mode != chb_pkg::MODE_IDE || !DMA_EN ||
                cmd.words == 8'h00))) begin
            rsp_next.err = 1'b1;
            rsp_v_next = 1'b1;
          end else if (cmd.op == chb_pkg::OP_DMA) begin
            st_next = S_DMA_WAIT;
          end else begin
            st_next = S_SETUP;
            cnt_next = chb_pkg::SETUP_CYC;
            pins_next.addr = {8'h00, cmd.reg_addr};
            pins_next.taskfile_select_n =
              (cmd.op == chb_pkg::OP_CTRL);
            pins_next.ctrl_block_select_n =
              (cmd.op != chb_pkg::OP_CTRL);
            if (cmd.op == chb_pkg::OP_DATA) begin
              pins_next.addr = {8'h00, chb_pkg::DATA_REG_ADDR};
              pins_next.data_out = cmd.wdata;
              pins_next.data_oe = cmd.wr ? chb_pkg::LANE_ALL
                : chb_pkg::LANE_NONE;
            end else begin
              pins_next.data_out = {8'h00, cmd.wdata[7:0]};
              pins_next.data_oe = cmd.wr ? chb_pkg::LANE_LOW
                : chb_pkg::LANE_NONE;
            end
          end
        end
      end
      S_SETUP, S_DMA_SETUP: begin
        cnt_next = dec(cnt_reg);
        if (cnt_reg == 8'h01) begin
          st_next = (st_reg == S_SETUP) ? S_STROBE : S_DMA_STROBE;
          cnt_next = chb_pkg::STROBE_CYC;
          pins_next.io_write_strobe_n = ~cmd_reg.wr;
          pins_next.io_read_strobe_n = cmd_reg.wr;
        end
      end
      S_STROBE, S_DMA_STROBE: begin
        cnt_next = dec(cnt_reg);
        if (!cmd_reg.wr) begin
          ack_next = ack_now;
        end
        if (cnt_reg == 8'h01) begin
          st_next = (st_reg == S_STROBE) ? S_HOLD : S_DMA_HOLD;
          cnt_next = chb_pkg::HOLD_CYC;
          pins_next.io_write_strobe_n = 1'b1;
          pins_next.io_read_strobe_n = 1'b1;
          // Sample before the strobe rises; the device stops then
          if (!cmd_reg.wr) begin
            rsp_next.data = (cmd_reg.op == chb_pkg::OP_DATA ||
              cmd_reg.op == chb_pkg::OP_DMA) ? data_s
              : {8'h00, data_s[7:0]};
            rsp_next.err = (mode_reg == chb_pkg::MODE_IO) &&
              !ack_now;
          end
        end
      end
      S_HOLD: begin
        cnt_next = dec(cnt_reg);
        if (cnt_reg == 8'h01) begin
          st_next = S_IDLE;
          pins_next = idle_pins(mode_reg, role_reg, a25_level);
          rsp_v_next = 1'b1;
        end
      end
      S_DMA_WAIT: begin
        // Grant only answers a standing request
        if (req_s) begin
          st_next = S_DMA_SETUP;
          cnt_next = chb_pkg::SETUP_CYC;
          pins_next.dma_grant_n = 1'b0;
          pins_next.taskfile_select_n = 1'b1;
          pins_next.ctrl_block_select_n = 1'b1;
          pins_next.data_out = dma_wr_data;
          pins_next.data_oe = cmd_reg.wr ? chb_pkg::LANE_ALL
            : chb_pkg::LANE_NONE;
          take_next = cmd_reg.wr;
        end
      end
      S_DMA_HOLD: begin
        cnt_next = dec(cnt_reg);
        if (cnt_reg == 8'h01) begin
          left_next = dec(left_reg);
          rsp_v_next = !cmd_reg.wr || (left_reg == 8'h01);
          if (left_reg == 8'h01) begin
            st_next = S_IDLE;
            pins_next = idle_pins(mode_reg, role_reg, a25_level);
          end else if (req_s) begin
            st_next = S_DMA_SETUP;
            cnt_next = chb_pkg::SETUP_CYC;
            pins_next.data_out = dma_wr_data;
            take_next = cmd_reg.wr;
          end else begin
            // Device paused; drop grant and wait for re-request
            st_next = S_DMA_WAIT;
            pins_next.dma_grant_n = 1'b1;
            pins_next.data_oe = chb_pkg::LANE_NONE;
          end
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    role_reg <= role_next;
    if (rst) begin
      st_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      left_reg <= 8'h00;
      cmd_reg <= '0;
      mode_reg <= chb_pkg::MODE_RESET;
      pins_reg <= chb_pkg::PINS_RESET;
      rsp_reg <= '0;
      ready_reg <= 1'b0;
      rsp_v_reg <= 1'b0;
      take_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      left_reg <= left_next;
      cmd_reg <= cmd_next;
      mode_reg <= mode_next;
      pins_reg <= pins_next;
      rsp_reg <= rsp_next;
      ready_reg <= ready_next;
      rsp_v_reg <= rsp_v_next;
      take_reg <= take_next;
      ack_reg <= ack_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_v_reg;
  assign rsp = rsp_reg;
  assign dma_wr_take = take_reg;
  assign pins = pins_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_role_ide: assert property (mode_reg == chb_pkg::MODE_IDE |->
      pins_reg.role_oe == role_reg && !pins_reg.role_out)
    else $error("role pin wrong in IDE mode");
  chk_role_other: assert property (mode_reg != chb_pkg::MODE_IDE |->
      pins_reg.role_oe)
    else $error("role pin left open outside IDE mode");
  chk_role_stable: assert property ($stable(role_reg))
    else $error("role changed outside reset");
  chk_tf_lanes: assert property ((cmd_reg.op != chb_pkg::OP_DATA &&
      !pins_reg.io_write_strobe_n && pins_reg.dma_grant_n) |->
      pins_reg.data_oe == chb_pkg::LANE_LOW && pins_reg.data_out[15:8] == 8'h00)
    else $error("task file write not byte wide");
  chk_read_release: assert property (!pins_reg.io_read_strobe_n |->
      pins_reg.data_oe == chb_pkg::LANE_NONE)
    else $error("host drives bus during read");
  chk_mem_quiet: assert property (mode_reg == chb_pkg::MODE_MEM |->
      pins_reg.io_read_strobe_n && pins_reg.io_write_strobe_n)
    else $error("strobe in memory mode");
  chk_one_dir: assert property (!(!pins_reg.io_read_strobe_n &&
      !pins_reg.io_write_strobe_n))
    else $error("both strobes asserted");
  chk_grant_req: assert property ($fell(pins_reg.dma_grant_n) |->
      $past(req_s))
    else $error("grant without request");
  chk_dma_selects: assert property (!pins_reg.dma_grant_n |->
      pins_reg.taskfile_select_n && pins_reg.ctrl_block_select_n)
    else $error("select asserted during DMA");
  chk_ctrl_select: assert property ((st_reg == S_STROBE &&
      cmd_reg.op == chb_pkg::OP_CTRL) |->
      !pins_reg.ctrl_block_select_n && pins_reg.taskfile_select_n)
    else $error("wrong select for control block");
  chk_addr_high: assert property (pins_reg.addr[10:3] == 8'h00)
    else $error("upper address lines not grounded");
  chk_ack_err: assert property (($rose(pins_reg.io_read_strobe_n) &&
      mode_reg == chb_pkg::MODE_IO) |-> rsp_reg.err == !ack_reg)
    else $error("I/O read result ignores input ack");
  chk_strobe_width: assert property ($fell(pins_reg.io_read_strobe_n) |->
      (!pins_reg.io_read_strobe_n) [*8])
    else $error("read strobe too short");

  cov_io_read: cover property ($rose(pins_reg.io_read_strobe_n) &&
    mode_reg == chb_pkg::MODE_IO);
  cov_dma_pause: cover property ($rose(pins_reg.dma_grant_n) &&
    st_reg == S_DMA_WAIT);
  cov_dma_done: cover property (rsp_v_reg && cmd_reg.op == chb_pkg::OP_DMA);
  cov_refused: cover property (rsp_v_reg && rsp_reg.err);

endmodule : chb_host_ctrl

//--- tb/chb_dev_model.sv
`timescale 1ns/10ps

// ==========================================================
// Card model at the far side of the host port, strobe driven
module chb_dev_model (
  input wire logic rst,
  input wire chb_pkg::chb_mode_t bus_mode,
  input wire chb_pkg::chb_pins_t pins,
  input wire logic [15:0] rd_word,
  input wire logic [7:0] dma_avail,
  output logic [15:0] data_in,
  output logic input_ack_n,
  output logic dma_req_out,
  output logic [15:0] last_wr,
  output logic [7:0] viol
);
  logic [7:0] done;
  logic sel;
  logic is_master;

  // Selected by either register select or by the DMA grant
  assign sel = !pins.taskfile_select_n || !pins.ctrl_block_select_n
    || !pins.dma_grant_n;

  // Bus only carries card data under the read strobe; else it shows the inverted word
  always_comb begin
    data_in = ~rd_word;
    if (!pins.io_read_strobe_n && sel
        && bus_mode != chb_pkg::MODE_MEM) begin
      data_in = rd_word;
    end
  end

  // Acknowledge only for an I/O read aimed at this card
  assign input_ack_n = !(bus_mode == chb_pkg::MODE_IO && sel
    && !pins.io_read_strobe_n);

  // Pulled low when not requesting, so an unselected card reads 0
  assign dma_req_out = bus_mode == chb_pkg::MODE_IDE
    && done < dma_avail;

  // Role pin sampled once at reset release; open pin means slave
  always @(negedge rst) begin
    is_master = pins.role_oe && !pins.role_out;
  end

  // A word moves on the trailing edge of either strobe under grant
  always @(posedge rst or posedge pins.io_read_strobe_n
      or posedge pins.io_write_strobe_n) begin
    if (rst) begin
      done <= 8'h00;
    end else if (!pins.dma_grant_n) begin
      done <= done + 8'h01;
    end
  end

  // Write data latched on the trailing edge of the write strobe
  always @(posedge pins.io_write_strobe_n) begin
    if (sel) begin
      last_wr <= pins.data_out;
    end
  end

  // Any register select while the grant is low counts as a fault
  always @(posedge rst or negedge pins.taskfile_select_n
      or negedge pins.ctrl_block_select_n or negedge pins.dma_grant_n) begin
    if (rst) begin
      viol <= 8'h00;
    end else if (!pins.dma_grant_n && !(pins.taskfile_select_n
        && pins.ctrl_block_select_n)) begin
      viol <= viol + 8'h01;
    end
  end
endmodule : chb_dev_model

//--- tb/tb_top.sv
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench for the host port controller
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  chb_pkg::chb_mode_t bus_mode = chb_pkg::MODE_IDE;
  logic a25_level = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  chb_pkg::chb_cmd_t cmd = '0;
  logic rsp_valid;
  chb_pkg::chb_rsp_t rsp;
  chb_pkg::chb_pins_t pins;
  logic [15:0] data_in;
  logic [15:0] rd_word = 16'h0000;
  logic input_ack_n;
  logic dma_req_out;
  logic [7:0] dma_avail = 8'h00;
  logic [15:0] last_wr;
  logic [7:0] viol;
  logic [1:0] oe_seen;
  logic [15:0] dma_wr_data = 16'h1000;
  logic dma_wr_take;
  int failures = 0;
  int checks = 0;

  // ========================================================
  // Clock, design and card model
  always #2.5 clk = ~clk;

  chb_host_ctrl chb_host_ctrl_inst (
    .clk(clk), .rst(rst), .bus_mode(bus_mode), .cfg_master(1'b1),
    .a25_level(a25_level), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .dma_wr_data(dma_wr_data), .dma_wr_take(dma_wr_take),
    .rsp_valid(rsp_valid),
    .rsp(rsp), .pins(pins), .data_in(data_in), .input_ack_n(input_ack_n),
    .dma_req_out(dma_req_out));

  chb_dev_model chb_dev_model_inst (
    .rst(rst), .bus_mode(bus_mode), .pins(pins), .rd_word(rd_word),
    .dma_avail(dma_avail), .data_in(data_in), .input_ack_n(input_ack_n),
    .dma_req_out(dma_req_out), .last_wr(last_wr), .viol(viol));

  // Lane enables seen at the start of each write strobe
  always @(negedge pins.io_write_strobe_n) oe_seen = pins.data_oe;

  // Next DMA write word offered once the current one is taken
  always @(posedge clk) begin
    if (dma_wr_take === 1'b1) begin
      dma_wr_data <= dma_wr_data + 16'h0001;
    end
  end

  // ========================================================
  // Shared tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Held until the edge that takes it, then dropped one step later
  task automatic issue(input chb_pkg::chb_op_t o, input logic w,
      input logic [2:0] ra, input logic [15:0] wd, input logic [7:0] n);
    int i;
    cmd = '{op: o, wr: w, reg_addr: ra, wdata: wd, words: n};
    cmd_valid = 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 200);
    #1;
    cmd_valid = 1'b0;
    if (i >= 200) begin
      failures++;
      conclude();
    end
  endtask : issue

  // DMA waits have no bound in the design, so the bench bounds them
  task automatic get_rsp();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp_valid !== 1'b1 && i < 5000);
    #1;
    if (i >= 5000) begin
      failures++;
      conclude();
    end
  endtask : get_rsp

  // ========================================================
  // Scenarios
  task automatic s_reset();
    repeat (3) @(posedge clk);
    #1;
    chk(pins, chb_pkg::PINS_RESET);
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({pins.role_oe, pins.role_out}, 2'b10);
    chk(chb_dev_model_inst.is_master, 1'b1);
    bus_mode = chb_pkg::MODE_IO;
    repeat (2) @(posedge clk);
    #1;
    chk({pins.role_oe, pins.role_out}, {1'b1, a25_level});
  endtask : s_reset

  task automatic s_mem();
    bus_mode = chb_pkg::MODE_MEM;
    issue(chb_pkg::OP_TF, 1'b0, 3'h1, 16'h0000, 8'h00);
    get_rsp();
    chk(rsp.err, 1'b1);
    chk(input_ack_n, 1'b1);
  endtask : s_mem

  task automatic s_io();
    bus_mode = chb_pkg::MODE_IO;
    issue(chb_pkg::OP_TF, 1'b1, 3'h2, 16'hab5a, 8'h00);
    get_rsp();
    chk(last_wr, 16'h005a);
    chk(oe_seen, chb_pkg::LANE_LOW);
    rd_word = 16'h1234;
    issue(chb_pkg::OP_TF, 1'b0, 3'h3, 16'h0000, 8'h00);
    get_rsp();
    chk(rsp, {16'h0034, 1'b0});
    issue(chb_pkg::OP_CTRL, 1'b0, 3'h6, 16'h0000, 8'h00);
    get_rsp();
    chk(rsp, {16'h0034, 1'b0});
  endtask : s_io

  task automatic s_ide_data();
    bus_mode = chb_pkg::MODE_IDE;
    rd_word = 16'hbeef;
    issue(chb_pkg::OP_DATA, 1'b0, chb_pkg::DATA_REG_ADDR, 16'h0, 8'h00);
    get_rsp();
    chk(rsp, {16'hbeef, 1'b0});
    issue(chb_pkg::OP_DATA, 1'b1, chb_pkg::DATA_REG_ADDR, 16'hc3a5, 8'h00);
    get_rsp();
    chk(last_wr, 16'hc3a5);
    chk(oe_seen, chb_pkg::LANE_ALL);
  endtask : s_ide_data

  // Two words read back to back, a two-word write, then a refusal outside IDE mode
  task automatic s_dma();
    rd_word = 16'h5aa5;
    dma_avail = 8'h02;
    issue(chb_pkg::OP_DMA, 1'b0, 3'h0, 16'h0000, 8'h02);
    get_rsp();
    chk(rsp, {16'h5aa5, 1'b0});
    get_rsp();
    chk(rsp, {16'h5aa5, 1'b0});
    repeat (4) @(posedge clk);
    #1;
    chk(dma_req_out, 1'b0);
    chk(pins.dma_grant_n, 1'b1);
    chk(viol, 8'h00);
    // Two-word DMA write: one answer at the end, each word taken once
    dma_avail = 8'h04;
    issue(chb_pkg::OP_DMA, 1'b1, 3'h0, 16'h0000, 8'h02);
    get_rsp();
    chk(rsp.err, 1'b0);
    chk(last_wr, 16'h1001);
    chk(oe_seen, chb_pkg::LANE_ALL);
    chk(dma_wr_data, 16'h1002);
    chk(viol, 8'h00);
    bus_mode = chb_pkg::MODE_IO;
    issue(chb_pkg::OP_DMA, 1'b0, 3'h0, 16'h0000, 8'h02);
    get_rsp();
    chk(rsp.err, 1'b1);
  endtask : s_dma

  initial begin
    s_reset();
    s_mem();
    s_io();
    s_ide_data();
    s_dma();
    conclude();
  end
endmodule : tb_top
